// File: logic/rtp_trace_port.sv
// Purpose: Real-time trace output, status nibble and data nibble
// Assumes: Core events are on i_clock; trace output clock comes from a pin
// Notes: Outputs advance once per rising edge of the trace output clock
`timescale 1ns/1ps

module rtp_trace_port #(
  parameter int DEPTH = rtp_pkg::FIFO_DEPTH
) (
  input wire logic i_clock,
  input wire logic i_arst_n,
  input wire logic i_trace_output_clock,
  input wire logic i_halted,
  input wire logic i_exc_emu,
  input wire logic i_exc_normal,
  input wire logic i_stopped,
  input wire logic i_evt_valid,
  input wire logic [2:0] i_evt_kind,
  input wire logic i_evt_variant,
  input wire logic i_evt_opnd_valid,
  input wire logic [1:0] i_evt_size,
  input wire logic [31:0] i_evt_data,
  input wire logic i_evt_to_user,
  input wire logic i_opnd_display_en,
  input wire logic [1:0] i_branch_target_bytes_field,
  input wire logic [3:0] i_breakpoint_state_field,
  output logic o_evt_ready,
  output logic o_stall,
  output logic [3:0] o_proc_status_nibble,
  output logic [3:0] o_debug_data_nibble
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  logic rst_n;

  // Release is synchronous so every flop leaves reset on the same edge
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_q <= rtp_pkg::RST_SYNC_RESET;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************
  // Store and decode
  // ****************************************
  localparam int CW = $clog2(DEPTH + 1);

  rtp_pkg::rtp_state_t st_q;
  rtp_pkg::rtp_state_t st_d;
  rtp_pkg::rtp_evt_t kind;
  logic tick;
  logic need_cap;
  logic [1:0] cap_size;
  logic full;
  logic accept;
  logic [rtp_pkg::DATA_W-1:0] head_data;
  logic [1:0] head_size;

  rtp_fifo_if #(.W(rtp_pkg::ENTRY_W), .CW(CW)) fq ();

  rtp_fifo #(
    .W(rtp_pkg::ENTRY_W),
    .DEPTH(DEPTH)
  ) u_store (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .bus(fq)
  );

  assign kind = rtp_pkg::rtp_evt_t'(i_evt_kind);
  assign tick = st_q.tsync[1] & ~st_q.tprev;
  assign head_data = fq.head[rtp_pkg::DATA_W-1:0];
  assign head_size = fq.head[rtp_pkg::ENTRY_W-1:rtp_pkg::DATA_W];

  // Which events put a value in the store
  always_comb begin
    need_cap = 1'b0;
    cap_size = i_evt_size;
    case (kind)
      rtp_pkg::RTP_EVT_WDATA: begin
        need_cap = 1'b1;
      end
      rtp_pkg::RTP_EVT_TAKEN: begin
        need_cap = i_evt_variant && (i_branch_target_bytes_field != 2'h0);
        cap_size = i_branch_target_bytes_field;
      end
      rtp_pkg::RTP_EVT_BEGIN: begin
        need_cap = i_evt_opnd_valid && i_opnd_display_en;
      end
      default: begin
        need_cap = 1'b0;
      end
    endcase
  end

  // The word being shifted out still occupies one of the two elements
  assign full = (32'(fq.count) + 32'(st_q.drain == rtp_pkg::RTP_DR_SHIFT)) >= DEPTH;
  assign o_stall = i_evt_valid && need_cap && full;
  assign o_evt_ready = accept;

  // ****************************************
  // Next state, one step per trace tick
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.tsync = {st_q.tsync[0], i_trace_output_clock};
    st_d.tprev = st_q.tsync[1];
    accept = 1'b0;
    fq.push = 1'b0;
    fq.push_data = {cap_size, i_evt_data};
    fq.pop = 1'b0;
    if (tick) begin
      // Data side: drain runs on its own, so status stays free
      if (st_q.drain == rtp_pkg::RTP_DR_SHIFT) begin
        st_d.dat = st_q.shift[3:0];
        st_d.shift = st_q.shift >> 4;
        if (st_q.cnt == '0) begin
          st_d.drain = rtp_pkg::RTP_DR_IDLE;
        end else begin
          st_d.cnt = st_q.cnt - 1'b1;
        end
      end else begin
        st_d.dat = {i_breakpoint_state_field[2:0], 1'b0};
      end
      // Status side, multi-cycle modes win over everything
      if (i_halted) begin
        st_d.proc_status_nibble = rtp_pkg::RTP_PST_HALT;
      end else if (i_exc_emu) begin
        st_d.proc_status_nibble = rtp_pkg::RTP_PST_EMU;
      end else if (i_exc_normal) begin
        st_d.proc_status_nibble = rtp_pkg::RTP_PST_EXC;
      end else if (i_stopped) begin
        st_d.proc_status_nibble = rtp_pkg::RTP_PST_STOP;
      end else if (st_q.drain == rtp_pkg::RTP_DR_IDLE && fq.count != '0) begin
        // Marker one tick ahead of its first nibble
        st_d.proc_status_nibble = rtp_pkg::rtp_pst_t'({rtp_pkg::MARK_HI, head_size});
        fq.pop = 1'b1;
        st_d.drain = rtp_pkg::RTP_DR_SHIFT;
        st_d.shift = head_data;
        st_d.cnt = {head_size, 1'b1};
      end else if (st_q.pend_user) begin
        st_d.proc_status_nibble = rtp_pkg::RTP_PST_USER;
        st_d.pend_user = 1'b0;
      end else if (i_evt_valid && !(need_cap && full)) begin
        accept = 1'b1;
        fq.push = need_cap;
        st_d.pend_user = i_evt_to_user;
        case (kind)
          rtp_pkg::RTP_EVT_TAKEN, rtp_pkg::RTP_EVT_RESYNC: begin
            st_d.proc_status_nibble = rtp_pkg::RTP_PST_TAKEN;
          end
          rtp_pkg::RTP_EVT_RTE: begin
            st_d.proc_status_nibble = rtp_pkg::RTP_PST_RTE;
          end
          rtp_pkg::RTP_EVT_PULSE, rtp_pkg::RTP_EVT_WDATA: begin
            st_d.proc_status_nibble = rtp_pkg::RTP_PST_PULSE;
          end
          default: begin
            st_d.proc_status_nibble = rtp_pkg::RTP_PST_BEGIN;
          end
        endcase
      end else begin
        // Continuing instruction, or stalled on a full store
        st_d.proc_status_nibble = rtp_pkg::RTP_PST_CONT;
      end
    end
  end

  // Register the whole state
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= rtp_pkg::ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_proc_status_nibble = st_q.proc_status_nibble;
  assign o_debug_data_nibble = st_q.dat;

  // ****************************************
  // Checks
  // ****************************************
  property p_no_reserved;
    @(posedge i_clock) disable iff (!rst_n)
    o_proc_status_nibble != 4'h2 && o_proc_status_nibble != 4'h6;
  endproperty
  a_no_reserved: assert property (p_no_reserved) else $error("reserved status code driven");

  property p_halt;
    @(posedge i_clock) disable iff (!rst_n)
    tick && i_halted |=> o_proc_status_nibble == 4'hF;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not shown as 0xF");

  property p_emu;
    @(posedge i_clock) disable iff (!rst_n)
    tick && !i_halted && i_exc_emu |=> o_proc_status_nibble == 4'hD;
  endproperty
  a_emu: assert property (p_emu) else $error("emulator exception not 0xD");

  property p_exc;
    @(posedge i_clock) disable iff (!rst_n)
    tick && !i_halted && !i_exc_emu && i_exc_normal |=> o_proc_status_nibble == 4'hC;
  endproperty
  a_exc: assert property (p_exc) else $error("exception not 0xC");

  property p_stop;
    @(posedge i_clock) disable iff (!rst_n)
    tick && i_stopped && !i_halted && !i_exc_emu && !i_exc_normal |=> o_proc_status_nibble == 4'hE;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not 0xE");

  property p_stall;
    @(posedge i_clock) disable iff (!rst_n)
    i_evt_valid && need_cap && full |-> !o_evt_ready && o_stall;
  endproperty
  a_stall: assert property (p_stall) else $error("capture taken into a full store");

  property p_marker;
    @(posedge i_clock) disable iff (!rst_n)
    $rose(st_q.drain == rtp_pkg::RTP_DR_SHIFT) |->
      o_proc_status_nibble >= 4'h8 && o_proc_status_nibble <= 4'hB;
  endproperty
  a_marker: assert property (p_marker) else $error("drain began without a marker");

  property p_nibble;
    @(posedge i_clock) disable iff (!rst_n)
    tick && st_q.drain == rtp_pkg::RTP_DR_SHIFT |=> o_debug_data_nibble == $past(st_q.shift[3:0]);
  endproperty
  a_nibble: assert property (p_nibble) else $error("data nibble not lowest first");

  property p_taken;
    @(posedge i_clock) disable iff (!rst_n)
    accept && (kind == rtp_pkg::RTP_EVT_TAKEN || kind == rtp_pkg::RTP_EVT_RESYNC)
      |=> o_proc_status_nibble == 4'h5;
  endproperty
  a_taken: assert property (p_taken) else $error("taken branch not 0x5");

  property p_idle_data;
    @(posedge i_clock) disable iff (!rst_n)
    tick && st_q.drain == rtp_pkg::RTP_DR_IDLE |=>
      o_debug_data_nibble == {$past(i_breakpoint_state_field[2:0]), 1'b0};
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("idle data nibble wrong");

  // Bound on occupancy: a broken full flag would let a third word in
  property p_store_bound;
    @(posedge i_clock) disable iff (!rst_n)
    32'(fq.count) <= DEPTH;
  endproperty
  a_store_bound: assert property (p_store_bound) else $error("store holds more than its depth");

  property p_no_overrun;
    @(posedge i_clock) disable iff (!rst_n)
    fq.push |-> !full;
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("value pushed while store full");

  property p_rte;
    @(posedge i_clock) disable iff (!rst_n)
    accept && kind == rtp_pkg::RTP_EVT_RTE |=> o_proc_status_nibble == 4'h7;
  endproperty
  a_rte: assert property (p_rte) else $error("exception return not 0x7");

  property p_pulse;
    @(posedge i_clock) disable iff (!rst_n)
    accept && (kind == rtp_pkg::RTP_EVT_PULSE || kind == rtp_pkg::RTP_EVT_WDATA)
      |=> o_proc_status_nibble == 4'h4;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse or data-write not 0x4");

  // User code waits only behind the modes and a due marker
  property p_user;
    @(posedge i_clock) disable iff (!rst_n)
    tick && st_q.pend_user && !i_halted && !i_exc_emu && !i_exc_normal && !i_stopped &&
      !(st_q.drain == rtp_pkg::RTP_DR_IDLE && fq.count != '0) |=> o_proc_status_nibble == 4'h3;
  endproperty
  a_user: assert property (p_user) else $error("user mode entry not 0x3");

  // A tick with nothing to report, or a stalled event, shows continue
  property p_cont;
    @(posedge i_clock) disable iff (!rst_n)
    tick && !accept && !st_q.pend_user && !i_halted && !i_exc_emu && !i_exc_normal && !i_stopped &&
      !(st_q.drain == rtp_pkg::RTP_DR_IDLE && fq.count != '0) |=> o_proc_status_nibble == 4'h0;
  endproperty
  a_cont: assert property (p_cont) else $error("idle or stalled tick not 0x0");

  // Analyzer samples once per link period, so nibbles must not move between ticks
  property p_hold;
    @(posedge i_clock) disable iff (!rst_n)
    !tick |=> $stable(o_proc_status_nibble) && $stable(o_debug_data_nibble);
  endproperty
  a_hold: assert property (p_hold) else $error("link output moved between ticks");

endmodule // rtp_trace_port

// File: logic/rtp_pkg.sv
// Purpose: Shared constants and types of the real-time trace port
// Assumes: Processor clock of 100 MHz; trace output clock sampled, not used as a clock
// Notes: Status codes 0x2 and 0x6 are left out of the code type on purpose
package rtp_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int DATA_W = 32;
  localparam int SIZE_W = 2;
  localparam int ENTRY_W = DATA_W + SIZE_W;
  localparam int FIFO_DEPTH = 2;
  localparam int CNT_W = 3;

  // ****************************************
  // Status nibble codes
  // ****************************************
  typedef enum logic [3:0] {
    RTP_PST_CONT = 4'h0,
    RTP_PST_BEGIN = 4'h1,
    RTP_PST_USER = 4'h3,
    RTP_PST_PULSE = 4'h4,
    RTP_PST_TAKEN = 4'h5,
    RTP_PST_RTE = 4'h7,
    RTP_PST_MARK1 = 4'h8,
    RTP_PST_MARK2 = 4'h9,
    RTP_PST_MARK3 = 4'hA,
    RTP_PST_MARK4 = 4'hB,
    RTP_PST_EXC = 4'hC,
    RTP_PST_EMU = 4'hD,
    RTP_PST_STOP = 4'hE,
    RTP_PST_HALT = 4'hF
  } rtp_pst_t;

  // Upper two bits of every size marker; low two bits are bytes minus one
  localparam logic [1:0] MARK_HI = 2'h2;

  // ****************************************
  // Events offered by the core
  // ****************************************
  typedef enum logic [2:0] {
    RTP_EVT_BEGIN = 3'h0,
    RTP_EVT_TAKEN = 3'h1,
    RTP_EVT_RESYNC = 3'h2,
    RTP_EVT_RTE = 3'h3,
    RTP_EVT_PULSE = 3'h4,
    RTP_EVT_WDATA = 3'h5
  } rtp_evt_t;

  // Drain machine, Gray along idle -> shift
  typedef enum logic [1:0] {
    RTP_DR_IDLE = 2'h0,
    RTP_DR_SHIFT = 2'h1
  } rtp_drain_t;

  // ****************************************
  // State of the top module
  // ****************************************
  typedef struct packed {
    logic [1:0] tsync;
    logic tprev;
    rtp_pst_t proc_status_nibble;
    logic [3:0] dat;
    rtp_drain_t drain;
    logic [DATA_W-1:0] shift;
    logic [CNT_W-1:0] cnt;
    logic pend_user;
  } rtp_state_t;

  localparam rtp_state_t ST_RESET = '0;
  localparam logic [1:0] RST_SYNC_RESET = 2'h0;

endpackage

// File: logic/rtp_fifo_if.sv
// Purpose: Carrier between the trace port and its two-entry store
// Assumes: One clock domain
// Notes: Head word is the store's own register, valid while count is non-zero
`timescale 1ns/1ps
interface rtp_fifo_if #(
  parameter int W = 34,
  parameter int CW = 2
);
  logic push;
  logic [W-1:0] push_data;
  logic pop;
  logic [W-1:0] head;
  logic [CW-1:0] count;

  modport fill (output push, output push_data, output pop, input head, input count);
  modport store (input push, input push_data, input pop, output head, output count);
endinterface

// File: logic/rtp_fifo.sv
// Purpose: Small store holding captured addresses and operands
// Assumes: Caller never pushes when full nor pops when empty
// Notes: Entries are flip-flops, so head data comes straight from a register
`timescale 1ns/1ps
module rtp_fifo #(
  parameter int W = 34,
  parameter int DEPTH = 2
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  rtp_fifo_if.store bus
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
  } rtp_fifo_state_t;

  rtp_fifo_state_t st_q;
  rtp_fifo_state_t st_d;

  // ****************************************
  // Next state
  // ****************************************
  // Pointers wrap explicitly so DEPTH need not be a power of two
  always_comb begin
    st_d = st_q;
    if (bus.push) begin
      st_d.mem[st_q.wptr] = bus.push_data;
      st_d.wptr = (st_q.wptr == PW'(DEPTH - 1)) ? '0 : st_q.wptr + 1'b1;
    end
    if (bus.pop) begin
      st_d.rptr = (st_q.rptr == PW'(DEPTH - 1)) ? '0 : st_q.rptr + 1'b1;
    end
    st_d.count = st_q.count + CW'(bus.push) - CW'(bus.pop);
  end

  // Register
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus.head = st_q.mem[st_q.rptr];
  assign bus.count = st_q.count;

endmodule // rtp_fifo

// File: testbench/rtp_analyzer.sv
// Purpose: Trace analyzer model at the far side of the trace port
// Assumes: Trace output clock runs free with a 125 ns period
// Notes: Samples mid-period; reports start codes and whole words
`timescale 1ns/1ps
module rtp_analyzer (
  output logic o_trace_clock,
  input wire logic [3:0] i_pst,
  input wire logic [3:0] i_dat,
  output logic o_code_valid,
  output logic [3:0] o_code,
  output logic o_word_valid,
  output logic [35:0] o_word
);
  // ****************
  // Link decoder
  // ****************
  int left;
  int idx;
  logic [35:0] acc;
  initial begin
    o_trace_clock = 1'b0;
    o_code_valid = 1'b0;
    o_word_valid = 1'b0;
    o_code = 4'h0;
    o_word = 36'h0;
    acc = 36'h0;
    left = 0;
    idx = 0;
  end
  // Free-running, not derived from the core clock
  always #62.5 o_trace_clock = ~o_trace_clock;
  // Falling edge sampling keeps clear of the output update
  always @(negedge o_trace_clock) begin
    if (left > 0) begin
      acc[4*idx +: 4] = i_dat;
      idx++;
      left--;
      if (left == 0) begin
        o_word = acc;
        o_word_valid = 1'b1;
      end
    end
    if (i_pst >= 4'h8 && i_pst <= 4'hB) begin
      acc = {i_pst, 32'h0};
      left = 2 * (32'(i_pst) - 7);
      idx = 0;
    end else if (i_pst >= 4'h1 && i_pst <= 4'h7) begin
      o_code = i_pst;
      o_code_valid = 1'b1;
    end
    #1;
    o_code_valid = 1'b0;
    o_word_valid = 1'b0;
  end
endmodule // rtp_analyzer

// File: testbench/rtp_trace_port_test.sv
// Purpose: Self-checking bench of the real-time trace port
// Assumes: Analyzer model watches both nibbles on the link clock
// Notes: Driver queues expected codes and words; watchers compare
`timescale 1ns/1ps
module rtp_trace_port_test;
  // ****************
  // Signals
  // ****************
  logic clock, arst_n, tclk, halted, emu, exc, stopped, valid, variant, opnd, to_user, disp_en;
  logic ready, stall, code_valid, word_valid, saw_stall;
  logic [2:0] kind;
  logic [1:0] size, branch_target_bytes_field;
  logic [31:0] data, seed;
  logic [3:0] bp, proc_status_nibble, dat, code;
  logic [35:0] word;
  logic [3:0] code_q[$];
  logic [35:0] word_q[$];
  logic [3:0] codes[8] = '{4'h1, 4'h5, 4'h5, 4'h7, 4'h4, 4'h4, 4'h1, 4'h1};
  logic [3:0] modes[4] = '{4'h9, 4'h6, 4'h3, 4'h1};
  logic [3:0] mcode[4] = '{4'hF, 4'hD, 4'hC, 4'hE};
  int n_mismatch, comparisons, i;

  rtp_trace_port rtp_trace_port_inst (.i_clock(clock), .i_arst_n(arst_n), .i_trace_output_clock(tclk),
    .i_halted(halted), .i_exc_emu(emu), .i_exc_normal(exc), .i_stopped(stopped), .i_evt_valid(valid),
    .i_evt_kind(kind), .i_evt_variant(variant), .i_evt_opnd_valid(opnd), .i_evt_size(size),
    .i_evt_data(data), .i_evt_to_user(to_user), .i_opnd_display_en(disp_en),
    .i_branch_target_bytes_field(branch_target_bytes_field), .i_breakpoint_state_field(bp), .o_evt_ready(ready),
    .o_stall(stall), .o_proc_status_nibble(proc_status_nibble), .o_debug_data_nibble(dat));
  rtp_analyzer rtp_analyzer_inst (.o_trace_clock(tclk), .i_pst(proc_status_nibble), .i_dat(dat),
    .o_code_valid(code_valid), .o_code(code), .o_word_valid(word_valid), .o_word(word));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Offer one event, note what the analyzer must report, hold until taken
  task automatic offer(input logic [2:0] k, input logic v, input logic o, input logic [1:0] s, input logic u);
    int n;
    logic [63:0] m;
    logic [3:0] mk;
    @(negedge clock);
    mk = 4'h0;
    data = rnd();
    kind = k;
    variant = v;
    opnd = o;
    size = s;
    to_user = u;
    code_q.push_back(codes[k]);
    if (u) code_q.push_back(4'h3);
    if (k == 3'h5 || (k == 3'h0 && o && disp_en)) mk = {2'h2, s};
    if (k == 3'h1 && v && branch_target_bytes_field != 2'h0) mk = {2'h2, branch_target_bytes_field};
    m = (64'h1 << (8 * (32'(mk[1:0]) + 1))) - 64'h1;
    if (mk != 4'h0) word_q.push_back({mk, data & m[31:0]});
    valid = 1'b1;
    n = 0;
    // Ready is combinational: look once inputs settle, so the taking edge is the next rising one
    #1;
    while (ready !== 1'b1 && n < 2000) begin
      if (stall === 1'b1) saw_stall = 1'b1;
      @(negedge clock);
      #1;
      n++;
    end
    check("ready", {35'h0, ready}, 36'h1);
    @(negedge clock);
    valid = 1'b0;
  endtask

  // Let queues empty, then linger to catch surplus reports
  task automatic drain(input string name);
    int n;
    n = 0;
    while ((code_q.size() + word_q.size()) != 0 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    repeat (200) @(negedge clock);
    check("leftover", 36'(code_q.size() + word_q.size()), 36'h0);
    $display("test %s done", name);
  endtask

  // ****************
  // Watchers
  // ****************
  always @(posedge code_valid) begin
    if (code_q.size() == 0) check("code", {32'h0, code}, 36'h0);
    else check("code", {32'h0, code}, {32'h0, code_q.pop_front()});
  end
  always @(posedge word_valid) begin
    if (word_q.size() == 0) check("word", word, 36'h0);
    else check("word", word, word_q.pop_front());
  end

  initial begin
    #800000;
    n_mismatch++;
    summarize();
  end

  // ****************
  // Tests
  // ****************
  initial begin
    {arst_n, halted, emu, exc, stopped, valid, variant, opnd, to_user, disp_en} = '0;
    {kind, size, branch_target_bytes_field, bp, data, saw_stall} = '0;
    n_mismatch = 0;
    comparisons = 0;
    seed = 32'h3B;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    // Idle data nibble follows breakpoint state
    for (i = 0; i < 4; i++) begin
      data = rnd();
      bp = data[3:0];
      repeat (40) @(negedge clock);
      check("idle", {32'h0, dat}, {32'h0, bp[2:0], 1'b0});
    end
    drain("idle");
    // Every kind, display and target bytes off
    for (i = 0; i < 8; i++) offer(3'(i), 1'b1, 1'b1, seed[1:0], 1'b0);
    drain("kinds");
    // Operand sizes and target byte counts
    disp_en = 1'b1;
    for (i = 0; i < 4; i++) begin
      branch_target_bytes_field = 2'(i);
      offer(3'h1, 1'b1, 1'b0, 2'h0, 1'b0);
      offer(3'h0, 1'b0, 1'b1, 2'(i), 1'b0);
    end
    offer(3'h1, 1'b0, 1'b0, 2'h0, 1'b0);
    drain("sizes");
    offer(3'h0, 1'b0, 1'b0, 2'h0, 1'b1);
    drain("user");
    // Three long operands back to back fill the store and stall the third
    saw_stall = 1'b0;
    for (i = 0; i < 3; i++) offer(3'h0, 1'b0, 1'b1, 2'h3, 1'b0);
    check("stall", {35'h0, saw_stall}, 36'h1);
    drain("stall");
    // Multi-cycle modes, with priority between them
    for (i = 0; i < 4; i++) begin
      {halted, emu, exc, stopped} = modes[i];
      repeat (40) @(negedge clock);
      check("mode", {32'h0, proc_status_nibble}, {32'h0, mcode[i]});
      {halted, emu, exc, stopped} = 4'h0;
      repeat (40) @(negedge clock);
    end
    drain("modes");
    summarize();
  end
endmodule // rtp_trace_port_test
